/* File: design/scl_top.sv */
// Channel control and enable latches for a four-channel serializer.
// Assumes an APB master on pclk, and gate/bus pins from asynchronous host logic.
// What this block does
// - Rate select low: complementary recovered clocks at character rate, capture on true rise.
// - Rate select high: half-rate complementary clocks, capture alternately on both.
// - Reference clock times both PLLs and may clock parallel interfaces.
// - Transmit source low: transmit interface clocked from reference derived character clock.
// - Rate range select: low 200-400, mid 400-800, high 800-1500 MBaud.
// - Loopback low: external serial input feeds that channel's receiver.
// - Loopback high: transmit stream routed into same channel's recovery circuit.
// - In loopback, serial output forced to one and external input ignored.
// - Output-enable gate high makes the latch transparent to the enable bus.
// - Output-enable bit high enables its driver, low powers it down.
// - Output-enable gate falling captures bus and holds until gate rises.
// - Reset presets output-enable latch with every driver enabled.
// - Self-test gate high makes the self-test latch transparent to the bus.
// - Self-test bit low selects test sequence, high selects normal data.
// - Self-test gate falling captures bus and holds it afterwards.
// - Reset presets self-test latch so self-test is disabled everywhere.
// - Active-low full-chip reset initialises control registers and gate state and presets latches; lane flops and clock divider are not reset.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module scl_top
   import scl_pkg::*;
#(
   parameter int unsigned CH = NUM_CH
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host pins
   input wire logic full_chip_reset_n,
   input wire logic output_enable_latch_gate,
   input wire logic selftest_latch_gate,
   input wire logic [7:0] shared_enable_bus,
   // Serial lanes
   input wire logic [CH-1:0] serial_data_in,
   input wire logic [CH-1:0] tx_serial_stream,
   output logic [CH-1:0] serial_data_out,
   output logic [CH-1:0] serial_driver_enable,
   output logic [CH-1:0] cdr_data_in,
   // Self-test enables, active low
   output logic [CH-1:0] tx_selftest_n,
   output logic [CH-1:0] rx_selftest_n,
   // Clocking controls
   input wire logic reference_clock_in,
   output logic [CH-1:0] recovered_char_clock,
   output logic [CH-1:0] recovered_char_clock_n,
   output logic tx_ref_clock_sel,
   output logic rx_ref_clock_sel,
   output logic [1:0] serial_rate_range_select,
   output logic recv_clock_rate_select
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [9:0] pin_s1_q;
   logic [9:0] pin_s2_q;
   logic [2*CH-1:0] ser_s1_q;
   logic [2*CH-1:0] ser_s2_q;
   logic [3:0] rst_sync_q;
   logic soft_rst_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 10'h000;
         pin_s2_q <= 10'h000;
      end else begin
         pin_s1_q <= {output_enable_latch_gate, selftest_latch_gate, shared_enable_bus};
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_s1_q <= '0;
         ser_s2_q <= '0;
      end else begin
         ser_s1_q <= {tx_serial_stream, serial_data_in};
         ser_s2_q <= ser_s1_q;
      end
   end

   // Reset starts low so the block stays in chip reset until the pin is seen high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_q <= 4'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[2:0], full_chip_reset_n};
      end
   end

   // Second and fourth stages of the reset sync are ANDed to feed logic; first and third feed only the next
   assign soft_rst_n = rst_sync_q[1] & rst_sync_q[3];

   logic oe_gate;
   logic st_gate;
   logic [7:0] en_bus;
   logic [CH-1:0] ext_in;
   logic [CH-1:0] tx_in;

   assign oe_gate = pin_s2_q[9];
   assign st_gate = pin_s2_q[8];
   assign en_bus = pin_s2_q[7:0];
   assign ext_in = ser_s2_q[CH-1:0];
   assign tx_in = ser_s2_q[2*CH-1:CH];

   // ------------------------------------------------------------
   // Enable latches
   // ------------------------------------------------------------
   // Gated flops instead of real latches: transparency lags the pins by
   // the synchroniser depth, traded for a single clean clock domain.
   scl_gate_e oe_state_q;
   scl_gate_e oe_state_d;
   scl_gate_e st_state_q;
   scl_gate_e st_state_d;
   logic [7:0] oe_latch_q;
   logic [7:0] oe_latch_d;
   logic [7:0] st_latch_q;
   logic [7:0] st_latch_d;

   assign oe_latch_d = oe_gate ? en_bus : oe_latch_q;
   assign st_latch_d = st_gate ? en_bus : st_latch_q;

   // Gate state is only reported; the latches follow the gate level directly
   always_comb begin
      oe_state_d = oe_state_q;
      case (oe_state_q)
         SCL_GATE_HOLD: begin
            if (oe_gate) begin
               oe_state_d = SCL_GATE_OPEN;
            end
         end
         SCL_GATE_OPEN: begin
            if (!oe_gate) begin
               oe_state_d = SCL_GATE_HOLD;
            end
         end
         default: begin
            oe_state_d = SCL_GATE_HOLD;
         end
      endcase
   end

   always_comb begin
      st_state_d = st_state_q;
      case (st_state_q)
         SCL_GATE_HOLD: begin
            if (st_gate) begin
               st_state_d = SCL_GATE_OPEN;
            end
         end
         SCL_GATE_OPEN: begin
            if (!st_gate) begin
               st_state_d = SCL_GATE_HOLD;
            end
         end
         default: begin
            st_state_d = SCL_GATE_HOLD;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_latch_q <= OE_RESET;
         oe_state_q <= SCL_GATE_HOLD;
      end else if (!soft_rst_n) begin
         oe_latch_q <= OE_RESET;
         oe_state_q <= SCL_GATE_HOLD;
      end else begin
         oe_latch_q <= oe_latch_d;
         oe_state_q <= oe_state_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_latch_q <= ST_RESET;
         st_state_q <= SCL_GATE_HOLD;
      end else if (!soft_rst_n) begin
         st_latch_q <= ST_RESET;
         st_state_q <= SCL_GATE_HOLD;
      end else begin
         st_latch_q <= st_latch_d;
         st_state_q <= st_state_d;
      end
   end

   // ------------------------------------------------------------
   // APB registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [CH-1:0] lpbk_q;
   scl_ctrl_s ctrl;
   logic wr_en;
   logic rd_ok;
   logic hit_ctrl;
   logic hit_lpbk;
   logic hit_stat;
   logic hit_latch;
   logic [31:0] rd_mux;
   logic [31:0] status_word;
   logic [31:0] latch_word;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic ctrl_wr;
   logic lpbk_wr;
   logic rd_err;
   logic wr_err;

   assign hit_ctrl = (paddr == REG_CTRL);
   assign hit_lpbk = (paddr == REG_LOOPBACK);
   assign hit_stat = (paddr == REG_STATUS);
   assign hit_latch = (paddr == REG_LATCHES);
   assign rd_ok = hit_ctrl | hit_lpbk | hit_stat | hit_latch;
   assign wr_en = psel & penable & pwrite & soft_rst_n;
   assign ctrl_wr = wr_en & hit_ctrl;
   assign lpbk_wr = wr_en & hit_lpbk;
   assign rd_err = ~rd_ok;
   // Status and latch words mirror hardware state, so writes there are refused
   assign wr_err = pwrite & (hit_stat | hit_latch);
   assign status_word = {{(28-CH){1'b0}}, oe_state_q, st_state_q, lpbk_q};
   assign latch_word = {16'h0000, st_latch_q, oe_latch_q};
   assign rd_mux = hit_ctrl ? ctrl_q :
                   hit_lpbk ? {{(32-CH){1'b0}}, lpbk_q} :
                   hit_stat ? status_word :
                   hit_latch ? latch_word : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (!soft_rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= {26'h0, pwdata[5:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpbk_q <= '0;
      end else if (!soft_rst_n) begin
         lpbk_q <= '0;
      end else if (lpbk_wr) begin
         lpbk_q <= pwdata[CH-1:0];
      end
   end

   // Read data is registered in the setup cycle so pready can sit high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q <= pwrite ? 32'h00000000 : rd_mux;
         pslverr_q <= rd_err | wr_err;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & psel & penable;

   // ------------------------------------------------------------
   // Clock and rate controls
   // ------------------------------------------------------------
   logic ref_rx_clocking;
   logic half_q;

   assign ctrl = '{
      rate_select: ctrl_q[CTRL_RATE_BIT],
      rx_source: ctrl_q[CTRL_RXSRC_BIT],
      tx_source: scl_level_e'(ctrl_q[CTRL_TXSRC_LSB +: 2]),
      speed: scl_level_e'(ctrl_q[CTRL_SPD_LSB +: 2])
   };

   // Host must keep rate low for reference clocking; not enforced here
   assign ref_rx_clocking = ~ctrl.rx_source;
   assign rx_ref_clock_sel = ref_rx_clocking;
   assign tx_ref_clock_sel = (ctrl.tx_source == SCL_LVL_LOW);
   assign serial_rate_range_select = ctrl.speed;
   assign recv_clock_rate_select = ctrl.rate_select;

   // Character clock stand-in, divided from pclk: full or half rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end

   // ------------------------------------------------------------
   // Per-channel lanes
   // ------------------------------------------------------------
   logic [CH-1:0] out_q;
   logic [CH-1:0] out_d;
   logic [CH-1:0] cdr_q;
   logic [CH-1:0] cdr_d;
   logic [CH-1:0] rclk_q;
   logic [CH-1:0] rclk_d;

   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_lane
         assign out_d[g] = lpbk_q[g] ? 1'b1 : tx_in[g];
         assign cdr_d[g] = lpbk_q[g] ? tx_in[g] : ext_in[g];
         // Half rate toggles only on every other pclk edge
         assign rclk_d[g] = ctrl.rate_select ? (half_q ? ~rclk_q[g] : rclk_q[g])
                                             : ~rclk_q[g];
         assign serial_driver_enable[g] = oe_latch_q[OE_BIT_BASE + g];
         assign tx_selftest_n[g] = st_latch_q[ST_TX_BIT_BASE + g];
         assign rx_selftest_n[g] = st_latch_q[ST_RX_BIT_BASE + g];
      end
   endgenerate

   // Serial outputs idle at logic one, the level a loopback lane shows anyway; CDR inputs and clocks reset to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '1;
         cdr_q <= '0;
         rclk_q <= '0;
      end else begin
         out_q <= out_d;
         cdr_q <= cdr_d;
         rclk_q <= rclk_d;
      end
   end

   assign serial_data_out = out_q;
   assign cdr_data_in = cdr_q;
   assign recovered_char_clock = rclk_q;
   assign recovered_char_clock_n = ~rclk_q;

endmodule

`default_nettype wire

/* File: design/scl_pkg.sv */
// Package for the serdes channel control latch block.
// Assumes a single 100 MHz pclk domain; host gate/bus and serial pins arrive asynchronously, APB pins on pclk.
package scl_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned EN_BUS_W = 8;

   // ------------------------------------------------------------
   // Enable bus mapping and reset values
   // ------------------------------------------------------------
   // Output enables use bits 0..3, one per channel driver
   localparam int unsigned OE_BIT_BASE = 0;
   // Self-test: transmit bits 0..3, receive bits 4..7
   localparam int unsigned ST_TX_BIT_BASE = 0;
   localparam int unsigned ST_RX_BIT_BASE = 4;
   localparam logic [7:0] OE_RESET = 8'hFF;
   localparam logic [7:0] ST_RESET = 8'hFF;

   // ------------------------------------------------------------
   // APB register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_LOOPBACK = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_LATCHES = 12'h00C;

   // CTRL field positions
   localparam int unsigned CTRL_RATE_BIT = 0;
   localparam int unsigned CTRL_RXSRC_BIT = 1;
   localparam int unsigned CTRL_TXSRC_LSB = 2;
   localparam int unsigned CTRL_SPD_LSB = 4;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [31:0] LOOPBACK_RESET = 32'h00000000;

   // ------------------------------------------------------------
   // Three-level selects and rate ranges
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SCL_LVL_LOW = 2'h0,
      SCL_LVL_MID = 2'h1,
      SCL_LVL_HIGH = 2'h2
   } scl_level_e;

   localparam int unsigned SPD_LOW_MIN_MBD = 200;
   localparam int unsigned SPD_LOW_MAX_MBD = 400;
   localparam int unsigned SPD_MID_MAX_MBD = 800;
   localparam int unsigned SPD_HIGH_MAX_MBD = 1500;

   // Gate state for each latch
   typedef enum logic [1:0] {
      SCL_GATE_HOLD = 2'b01,
      SCL_GATE_OPEN = 2'b10
   } scl_gate_e;

   typedef struct packed {
      logic rate_select;
      logic rx_source;
      scl_level_e tx_source;
      scl_level_e speed;
   } scl_ctrl_s;

endpackage

/* File: test/scl_top_checker.sv */
// Port assertions for the channel control block.
// Assumes a single pclk domain; bound into scl_top.
`timescale 1ns/1ps
`default_nettype none
module scl_top_checker
   import scl_pkg::*;
#(
   parameter int unsigned CH = NUM_CH
) (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic full_chip_reset_n,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Pins and outputs
   input wire logic output_enable_latch_gate,
   input wire logic selftest_latch_gate,
   input wire logic [7:0] shared_enable_bus,
   input wire logic [CH-1:0] serial_driver_enable,
   input wire logic [CH-1:0] tx_selftest_n,
   input wire logic [CH-1:0] rx_selftest_n,
   input wire logic [CH-1:0] recovered_char_clock,
   input wire logic [CH-1:0] recovered_char_clock_n,
   input wire logic [1:0] serial_rate_range_select,
   input wire logic recv_clock_rate_select
);
   // Chip reset passes a synchroniser, so early cycles after it prove nothing
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic live;
   assign quiet_d = !full_chip_reset_n ? 4'h0 : (live ? quiet_q : quiet_q + 4'h1);
   assign live = (quiet_q == 4'hF);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_q <= 4'h0;
      end else begin
         quiet_q <= quiet_d;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn || !live);
   sequence oe_open_s;
      (output_enable_latch_gate && $stable(shared_enable_bus))[*6];
   endsequence
   sequence st_open_s;
      (selftest_latch_gate && $stable(shared_enable_bus))[*6];
   endsequence
   chk_clk_pair: assert property (recovered_char_clock == ~recovered_char_clock_n)
      else $error("recovered clock pair not complementary");
   chk_full_rate: assert property (!recv_clock_rate_select [*4] |->
      recovered_char_clock == ~$past(recovered_char_clock)) else $error("full rate clock wrong");
   chk_half_rate: assert property (recv_clock_rate_select [*4] |->
      recovered_char_clock == ~$past(recovered_char_clock, 2)) else $error("half rate clock wrong");
   chk_ctrl_write: assert property (psel && penable && pwrite && paddr == REG_CTRL |=>
      serial_rate_range_select == $past(pwdata[5:4])) else $error("rate range not applied");
   chk_oe_follow: assert property (oe_open_s |->
      serial_driver_enable == shared_enable_bus[OE_BIT_BASE +: CH]) else $error("oe not open");
   chk_oe_hold: assert property (!output_enable_latch_gate [*8] |->
      $stable(serial_driver_enable)) else $error("oe changed while closed");
   chk_st_follow: assert property (st_open_s |-> rx_selftest_n ==
      shared_enable_bus[ST_RX_BIT_BASE +: CH]) else $error("selftest not open");
   chk_st_hold: assert property (!selftest_latch_gate [*8] |->
      $stable({tx_selftest_n, rx_selftest_n})) else $error("selftest changed while closed");
endmodule
bind scl_top scl_top_checker #(.CH(CH)) u_chk (.pclk(pclk), .presetn(presetn),
   .full_chip_reset_n(full_chip_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .output_enable_latch_gate(output_enable_latch_gate),
   .selftest_latch_gate(selftest_latch_gate), .shared_enable_bus(shared_enable_bus),
   .serial_driver_enable(serial_driver_enable), .tx_selftest_n(tx_selftest_n),
   .rx_selftest_n(rx_selftest_n), .recovered_char_clock(recovered_char_clock),
   .recovered_char_clock_n(recovered_char_clock_n),
   .serial_rate_range_select(serial_rate_range_select),
   .recv_clock_rate_select(recv_clock_rate_select));
`default_nettype wire

/* File: test/scl_host_model.sv */
// Host logic model driving the latch gates and the shared enable bus.
// Assumes the bench calls load and nothing else drives these pins.
`timescale 1ns/1ps
`default_nettype none
module scl_host_model (
   // Clock
   input wire logic pclk,
   // Pins
   output logic oe_gate,
   output logic st_gate,
   output logic [7:0] bus
);
   initial begin
      oe_gate = 1'b0;
      st_gate = 1'b0;
      bus = 8'hFF;
   end
   task automatic load(input logic sel_st, input logic [7:0] v);
      @(posedge pclk);
      bus <= v;
      oe_gate <= !sel_st;
      st_gate <= sel_st;
      repeat (8) @(posedge pclk);
      oe_gate <= 1'b0;
      st_gate <= 1'b0;
      repeat (8) @(posedge pclk);
      // Released bus shows a new value so a leaky latch is caught
      bus <= ~v;
      repeat (8) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* File: test/scl_top_tb_top.sv */
// Self-checking bench for the channel control block.
// Assumes a 100 MHz clock and the host model on the latch pins.
`timescale 1ns/1ps
`default_nettype none
module scl_top_tb_top;
   import scl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic full_chip_reset_n = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, oe_gate, st_gate, txr, rxr, rsel;
   logic [7:0] bus;
   logic [3:0] sin = 4'h0;
   logic [3:0] stx = 4'h0;
   logic [3:0] sout, drv, cdr, txst, rxst;
   logic [1:0] spd;
   int n_errors = 0;
   int samples_checked = 0;
   always #5 pclk = ~pclk;
   scl_host_model u_host (.pclk(pclk), .oe_gate(oe_gate), .st_gate(st_gate), .bus(bus));
   scl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .full_chip_reset_n(full_chip_reset_n),
      .output_enable_latch_gate(oe_gate), .selftest_latch_gate(st_gate),
      .shared_enable_bus(bus), .serial_data_in(sin), .tx_serial_stream(stx),
      .serial_data_out(sout), .serial_driver_enable(drv), .cdr_data_in(cdr),
      .tx_selftest_n(txst), .rx_selftest_n(rxst), .reference_clock_in(1'b0),
      .recovered_char_clock(), .recovered_char_clock_n(), .tx_ref_clock_sel(txr),
      .rx_ref_clock_sel(rxr), .serial_rate_range_select(spd), .recv_clock_rate_select(rsel));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_errors++;
         complete_run();
      end
   endtask
   // Preset state shared by both kinds of reset
   task automatic reset_vals();
      check("drv", 32'(drv), 32'hF);
      check("selftest", 32'({txst, rxst}), 32'hFF);
      apb(1'b0, REG_LATCHES, 32'h0);
      check("latches", rd, 32'h0000FFFF);
   endtask
   initial begin
      logic [31:0] v;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      reset_vals();
      for (int k = 0; k < 3; k++) begin
         v = 32'((k << 4) | (k << 2) | ((k & 1) * 3));
         apb(1'b1, REG_CTRL, v);
         apb(1'b0, REG_CTRL, 32'h0);
         check("ctrl", rd, v);
         check("spd", 32'(spd), 32'(k));
         check("txr", 32'(txr), 32'(k == 0));
         check("rxr", 32'(rxr), 32'(!(k & 1)));
         check("rsel", 32'(rsel), 32'(k & 1));
      end
      apb(1'b1, REG_CTRL, 32'h0);
      u_host.load(1'b0, 8'hA5);
      check("oe", 32'(drv), 32'h5);
      check("st_kept", 32'({txst, rxst}), 32'hFF);
      u_host.load(1'b1, 8'h3C);
      check("txst", 32'(txst), 32'hC);
      check("rxst", 32'(rxst), 32'h3);
      apb(1'b0, REG_LATCHES, 32'h0);
      check("latches", rd, 32'h00003CA5);
      sin <= 4'hA;
      stx <= 4'hC;
      repeat (6) @(posedge pclk);
      check("cdr", 32'(cdr), 32'hA);
      apb(1'b1, REG_LOOPBACK, 32'h3);
      sin <= 4'h5;
      repeat (6) @(posedge pclk);
      check("cdr_lb", 32'(cdr), 32'h4);
      check("out_lb", 32'(sout[1:0]), 32'h3);
      apb(1'b0, REG_STATUS, 32'h0);
      check("status", rd, 32'h00000053);
      check("ok_err", 32'(err), 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check("bad_err", 32'(err), 32'h1);
      check("bad_rd", rd, 32'h0);
      apb(1'b1, REG_STATUS, 32'hFF);
      check("ro_err", 32'(err), 32'h1);
      full_chip_reset_n <= 1'b0;
      repeat (6) @(posedge pclk);
      full_chip_reset_n <= 1'b1;
      repeat (12) @(posedge pclk);
      reset_vals();
      check("cdr_rst", 32'(cdr), 32'h5);
      complete_run();
   end
endmodule
`default_nettype wire
